// file: rtl/rrc_pkg.sv
// Package with opcode fields, phase encoding and reset values for the return/rotate unit
package rrc_pkg;
  localparam logic [14:0] RRC_RET_OPC = 15'h0009;
  localparam logic [5:0] RRC_ROT_OPC = 6'h0D;
  localparam int RRC_ROT_OP_MSB = 15;
  localparam int RRC_ROT_OP_LSB = 10;
  localparam int RRC_D_BIT = 9;
  localparam int RRC_A_BIT = 8;
  localparam int RRC_C_BIT = 0;
  localparam int RRC_Z_BIT = 2;
  localparam int RRC_N_BIT = 4;
  localparam logic [3:0] RRC_BANK_ACCESS = 4'h0;
  localparam logic [7:0] RRC_W_RST = 8'h00;
  localparam logic [7:0] RRC_FLAG_RST = 8'h00;
  localparam logic [3:0] RRC_BANK_RST = 4'h0;
  localparam logic [20:0] RRC_PC_RST = 21'h000000;
  localparam logic [1:0] RRC_Q1 = 2'h0;
  localparam logic [1:0] RRC_Q2 = 2'h1;
  localparam logic [1:0] RRC_Q3 = 2'h2;
  localparam logic [1:0] RRC_Q4 = 2'h3;
  typedef enum logic [1:0] {RRC_IDLE, RRC_RET_WAIT, RRC_RET_IDLE2} rrc_state_t;
endpackage

// file: rtl/rrc_exec.sv
// Execution unit for return-from-subroutine and rotate-left-through-carry
//
// Contract
// (RQ1) Return opcode pops the stack and loads the popped top entry into PC.
// (RQ2) Return with restore set copies working, flag and bank shadows back.
// (RQ3) Return with restore clear leaves working, flag and bank pointer alone.
// (RQ4) Return never touches PC latches nor flags except a requested restore.
// (RQ5) Rotate shifts left through carry; updates carry, negative and zero flags.
// (RQ6) Rotate destination bit zero writes working register, one writes back.
// (RQ7) Rotate access bit zero uses access bank, one uses bank pointer.
// (RQ8) Return takes two cycles, popping in Q4; rotate completes in one.
`timescale 1ns/100ps
module rrc_exec (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] q_phase,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [20:0] stack_top_entry,
  input wire logic [7:0] working_reg_shadow,
  input wire logic [7:0] flag_reg_shadow,
  input wire logic [3:0] bank_pointer_shadow,
  input wire logic [7:0] file_rd_data,
  output logic stack_pop,
  output logic [20:0] pc_q,
  output logic [7:0] working_reg_q,
  output logic [7:0] flag_reg_q,
  output logic [3:0] bank_pointer_q,
  output logic file_rd_en,
  output logic file_wr_en,
  output logic [3:0] file_bank,
  output logic [7:0] file_addr,
  output logic [7:0] file_wr_data,
  output logic busy
);
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  rrc_pkg::rrc_state_t state_q;
  rrc_pkg::rrc_state_t state_d;
  logic [15:0] ir_q;
  logic [7:0] oper_q;
  logic ir_valid_q;
  wire is_ret = instr_word[15:1] == rrc_pkg::RRC_RET_OPC;
  wire is_rot = instr_word[rrc_pkg::RRC_ROT_OP_MSB:rrc_pkg::RRC_ROT_OP_LSB]
    == rrc_pkg::RRC_ROT_OPC;
  wire q1 = q_phase == rrc_pkg::RRC_Q1;
  wire q2 = q_phase == rrc_pkg::RRC_Q2;
  wire q4 = q_phase == rrc_pkg::RRC_Q4;
  wire take = q1 && instr_valid && state_q == rrc_pkg::RRC_IDLE;
  wire ir_ret = ir_q[15:1] == rrc_pkg::RRC_RET_OPC;
  wire ir_rot = ir_q[rrc_pkg::RRC_ROT_OP_MSB:rrc_pkg::RRC_ROT_OP_LSB]
    == rrc_pkg::RRC_ROT_OPC;
  wire ir_restore = ir_q[0];
  wire ir_dest_f = ir_q[rrc_pkg::RRC_D_BIT];
  wire ir_use_bank = ir_q[rrc_pkg::RRC_A_BIT];
  // Read address must already stand while the Q2 read is under way,
  // so the decode edge takes it straight from the incoming word
  wire new_use_bank = instr_word[rrc_pkg::RRC_A_BIT];
  wire [3:0] new_bank = new_use_bank ? bank_pointer_q : rrc_pkg::RRC_BANK_ACCESS; // RQ7
  wire [3:0] sel_bank = ir_use_bank ? bank_pointer_q : rrc_pkg::RRC_BANK_ACCESS; // RQ7
  wire [3:0] bank_d = take ? new_bank : sel_bank;
  wire [7:0] addr_d = take ? instr_word[7:0] : ir_q[7:0];
  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  wire [7:0] rot_res = {oper_q[6:0], flag_reg_q[rrc_pkg::RRC_C_BIT]}; // RQ5
  wire rot_c = oper_q[7]; // RQ5
  wire rot_zero = rot_res == 8'h00; // RQ5
  logic [7:0] rot_flags;
  wire ret_pop = ir_ret && q4 && state_q == rrc_pkg::RRC_RET_WAIT; // RQ8
  wire rot_wb = ir_rot && q4 && state_q == rrc_pkg::RRC_IDLE && ir_valid_q; // RQ8

  // Only carry, negative and zero move; other flag bits pass through
  always_comb begin
    rot_flags = flag_reg_q;
    rot_flags[rrc_pkg::RRC_C_BIT] = rot_c; // RQ5
    rot_flags[rrc_pkg::RRC_N_BIT] = rot_res[7]; // RQ5
    rot_flags[rrc_pkg::RRC_Z_BIT] = rot_zero; // RQ5
  end
  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------

  always_comb begin
    state_d = state_q;
    case (state_q)
      rrc_pkg::RRC_IDLE: begin
        if (take && is_ret) begin
          state_d = rrc_pkg::RRC_RET_WAIT;
        end
      end
      rrc_pkg::RRC_RET_WAIT: begin
        if (q4) begin
          state_d = rrc_pkg::RRC_RET_IDLE2;
        end
      end
      default: begin
        if (q4) begin
          state_d = rrc_pkg::RRC_IDLE; // RQ8
        end
      end
    endcase
  end
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= rrc_pkg::RRC_IDLE;
      ir_q <= 16'h0000;
      ir_valid_q <= 1'b0;
      oper_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (take) begin
        ir_q <= instr_word;
        ir_valid_q <= is_rot || is_ret;
      end else if (q4 && state_q == rrc_pkg::RRC_IDLE) begin
        ir_valid_q <= 1'b0;
      end
      if (q2 && ir_rot) begin
        oper_q <= file_rd_data;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pc_q <= rrc_pkg::RRC_PC_RST;
      working_reg_q <= rrc_pkg::RRC_W_RST;
      flag_reg_q <= rrc_pkg::RRC_FLAG_RST;
      bank_pointer_q <= rrc_pkg::RRC_BANK_RST;
      stack_pop <= 1'b0;
    end else begin
      stack_pop <= 1'b0;
      // Pop lands on the first Q4; the second instruction cycle is an idle slot
      if (ret_pop) begin
        pc_q <= stack_top_entry; // RQ1
        stack_pop <= 1'b1; // RQ1
        if (ir_restore) begin // RQ3 RQ4
          working_reg_q <= working_reg_shadow; // RQ2
          flag_reg_q <= flag_reg_shadow; // RQ2
          bank_pointer_q <= bank_pointer_shadow; // RQ2
        end
      end else if (rot_wb) begin
        flag_reg_q <= rot_flags; // RQ5
        if (!ir_dest_f) begin
          working_reg_q <= rot_res; // RQ6
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      file_rd_en <= 1'b0;
      file_wr_en <= 1'b0;
      file_bank <= 4'h0;
      file_addr <= 8'h00;
      file_wr_data <= 8'h00;
      busy <= 1'b0;
    end else begin
      file_rd_en <= take && is_rot;
      file_wr_en <= rot_wb && ir_dest_f; // RQ6
      file_bank <= bank_d; // RQ7
      file_addr <= addr_d;
      file_wr_data <= rot_res;
      busy <= state_d != rrc_pkg::RRC_IDLE;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_pop_loads_pc: assert property ( // RQ1
    stack_pop |-> pc_q == $past(stack_top_entry))
    else $error("PC not loaded from stack top on pop");
  a_restore_shadow: assert property ( // RQ2
    stack_pop && ir_restore |-> working_reg_q == $past(working_reg_shadow)
    && flag_reg_q == $past(flag_reg_shadow) && bank_pointer_q == $past(bank_pointer_shadow))
    else $error("Shadow restore missing");
  a_no_restore: assert property ( // RQ3
    stack_pop && !ir_restore |-> $stable(working_reg_q) && $stable(bank_pointer_q))
    else $error("Registers changed without restore");
  a_flags_kept: assert property (stack_pop && !ir_restore |-> $stable(flag_reg_q)) // RQ4
    else $error("Flags changed by plain return");
  a_rot_carry: assert property ( // RQ5
    $past(rot_wb) |-> flag_reg_q[rrc_pkg::RRC_C_BIT] == $past(oper_q[7]))
    else $error("Carry not from old bit 7");
  a_rot_neg: assert property ( // RQ5
    $past(rot_wb) |-> flag_reg_q[rrc_pkg::RRC_N_BIT] == $past(oper_q[6]))
    else $error("Negative flag not from old bit 6");
  a_rot_zero: assert property ( // RQ5
    $past(rot_wb) |-> flag_reg_q[rrc_pkg::RRC_Z_BIT] ==
    ($past(oper_q[6:0]) == 7'h00 && !$past(flag_reg_q[rrc_pkg::RRC_C_BIT])))
    else $error("Zero flag does not match result");
  a_rot_dest_w: assert property ( // RQ6
    $past(rot_wb) && !$past(ir_dest_f) |-> working_reg_q == $past(rot_res) && !file_wr_en)
    else $error("Rotate result not in working register");
  a_rot_dest_f: assert property ( // RQ6
    $past(rot_wb) && $past(ir_dest_f) |-> file_wr_en && $stable(working_reg_q))
    else $error("Rotate result not written back to file");
  a_rot_wr_data: assert property ( // RQ5
    file_wr_en |-> file_wr_data == {$past(oper_q[6:0]), $past(flag_reg_q[rrc_pkg::RRC_C_BIT])})
    else $error("Write-back data is not the rotated value");
  a_rot_bank: assert property ( // RQ7
    file_wr_en |-> file_bank ==
    ($past(ir_use_bank) ? $past(bank_pointer_q) : rrc_pkg::RRC_BANK_ACCESS))
    else $error("Wrong bank selected");
  a_rd_target: assert property ( // RQ7
    file_rd_en |-> file_addr == ir_q[7:0]
    && file_bank == (ir_use_bank ? bank_pointer_q : rrc_pkg::RRC_BANK_ACCESS))
    else $error("Read issued to wrong bank or address");
  a_ret_two_cyc: assert property (take && is_ret |-> ##1 !stack_pop [*3] ##1 stack_pop) // RQ8
    else $error("Return pop timing wrong");
  a_rot_one_cyc: assert property (take && is_rot |-> ##3 rot_wb) // RQ8
    else $error("Rotate did not write back in its own cycle");
  a_pop_single: assert property (stack_pop |=> !stack_pop [*7]) // RQ8
    else $error("Return popped the stack more than once");
  c_ret_restore: cover property (stack_pop && ir_restore);
  c_ret_plain: cover property (stack_pop && !ir_restore);
  c_rot_to_f: cover property (file_wr_en);
  c_rot_to_w: cover property (rot_wb && !ir_dest_f);
  c_rot_zero: cover property (rot_wb && rot_zero);
endmodule

// file: tb/return_and_rotate_carry_exec_tb.sv
// Self-checking bench for the return and rotate-through-carry unit
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module return_and_rotate_carry_exec_tb;
  logic sys_clk = 1'b0, rst = 1'b1, instr_valid = 1'b0;
  logic [1:0] q_phase = rrc_pkg::RRC_Q1;
  logic [15:0] instr_word = 16'h0000;
  logic [20:0] stack_top_entry = 21'h000000;
  logic [7:0] w_shadow = 8'h3C, f_shadow = 8'h05, file_rd_data = 8'h00;
  logic [3:0] b_shadow = 4'hA;
  wire stack_pop, file_rd_en, file_wr_en, busy;
  wire [20:0] pc_q;
  wire [7:0] working_reg_q, flag_reg_q, file_addr, file_wr_data;
  wire [3:0] bank_pointer_q, file_bank;
  int n_fail = 0, comparisons = 0, n_rd, n_wr, n_pop, n_busy;
  logic [7:0] rd_addr, wr_data;
  logic [3:0] rd_bank;
  rrc_exec dut (.sys_clk(sys_clk), .rst(rst), .q_phase(q_phase), .instr_valid(instr_valid),
    .instr_word(instr_word), .stack_top_entry(stack_top_entry),
    .working_reg_shadow(w_shadow), .flag_reg_shadow(f_shadow),
    .bank_pointer_shadow(b_shadow), .file_rd_data(file_rd_data), .stack_pop(stack_pop),
    .pc_q(pc_q), .working_reg_q(working_reg_q), .flag_reg_q(flag_reg_q),
    .bank_pointer_q(bank_pointer_q), .file_rd_en(file_rd_en), .file_wr_en(file_wr_en),
    .file_bank(file_bank), .file_addr(file_addr), .file_wr_data(file_wr_data), .busy(busy));
  // ----------------------------------------
  // Clock and quarter phase
  // ----------------------------------------
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    q_phase <= rst ? rrc_pkg::RRC_Q1 : q_phase + 2'h1;
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  // Issues one word at a Q1 edge, then counts pulses over nine clock cycles
  task automatic exec(input logic [15:0] w, input logic [7:0] rd, input logic [20:0] st);
    int i;
    @(negedge sys_clk);
    for (i = 0; i < 4 && q_phase !== rrc_pkg::RRC_Q4; i++) @(negedge sys_clk);
    `CHK(q_phase, rrc_pkg::RRC_Q4)
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    file_rd_data <= rd;
    stack_top_entry <= st;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    {n_rd, n_wr, n_pop, n_busy} = '0;
    {rd_bank, rd_addr, wr_data} = 'x;
    repeat (9) begin
      @(negedge sys_clk);
      n_rd += int'(file_rd_en === 1'b1);
      n_wr += int'(file_wr_en === 1'b1);
      n_pop += int'(stack_pop === 1'b1);
      n_busy += int'(busy === 1'b1);
      if (file_rd_en === 1'b1) {rd_bank, rd_addr} = {file_bank, file_addr};
      if (file_wr_en === 1'b1) wr_data = file_wr_data;
    end
  endtask
  task automatic ret(input logic s, input logic [20:0] st, input logic [7:0] ew, ef,
      input logic [3:0] eb);
    exec({rrc_pkg::RRC_RET_OPC, s}, 8'h00, st);
    `CHK(pc_q, st)
    `CHK(n_pop, 1)
    `CHK(n_busy, 7)
    `CHK(busy, 1'b0)
    `CHK(working_reg_q, ew)
    `CHK(flag_reg_q, ef)
    `CHK(bank_pointer_q, eb)
  endtask
  task automatic rot(input logic d, a, input logic [7:0] rd, er, ew, ef, input logic [3:0] eb);
    exec({rrc_pkg::RRC_ROT_OPC, d, a, 8'h5A}, rd, pc_q);
    `CHK(working_reg_q, ew)
    `CHK(flag_reg_q, ef)
    `CHK(file_bank, eb)
    `CHK(file_addr, 8'h5A)
    `CHK(rd_bank, eb)
    `CHK(rd_addr, 8'h5A)
    `CHK(n_rd, 1)
    `CHK(n_wr, int'(d))
    `CHK(n_pop, 0)
    if (d) `CHK(wr_data, er)
  endtask
  task automatic end_of_test;
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    `CHK({pc_q, working_reg_q, flag_reg_q, bank_pointer_q, busy}, 42'h0)
    rot(1'b0, 1'b0, 8'hE6, 8'hCC, 8'hCC, 8'h11, rrc_pkg::RRC_BANK_ACCESS);
    ret(1'b0, 21'h1ABCDE, 8'hCC, 8'h11, 4'h0);
    ret(1'b1, 21'h0F0F0F, 8'h3C, 8'h05, 4'hA);
    rot(1'b1, 1'b1, 8'h80, 8'h01, 8'h3C, 8'h01, 4'hA);
    rot(1'b0, 1'b1, 8'h7F, 8'hFF, 8'hFF, 8'h10, 4'hA);
    rot(1'b0, 1'b0, 8'h80, 8'h00, 8'h00, 8'h05, rrc_pkg::RRC_BANK_ACCESS);
    exec(16'h0006, 8'hFF, 21'h055555);
    `CHK({pc_q, working_reg_q, flag_reg_q}, {21'h0F0F0F, 16'h0005})
    `CHK(n_pop + n_rd + n_wr, 0)
    end_of_test();
  end
endmodule
